// >>> hdl/switch_ctrl_map.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * global switch control bank.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef SWITCH_CTRL_MAP_SVH
`define SWITCH_CTRL_MAP_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define OFS_FILTER_IPMC_CTRL    8'h86
`define OFS_RATE_LIMIT_CTRL     8'h87
`define OFS_DSCP_MAP_BASE       8'h90
`define OFS_DSCP_MAP_CODES_4_7  8'h91

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_SELF_FILTER_EN      6
`define BIT_IPMC_FWD_EN         5
`define FLD_IPMC_MAP_HI         4
`define FLD_IPMC_MAP_LO         0
`define FLD_RL_PERIOD_HI        5
`define FLD_RL_PERIOD_LO        4
`define BIT_EGR_QUEUE_MODE      3
`define BIT_MAC_GROUP           40

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_SELF_FILTER_EN      1'b0
`define RST_IPMC_FWD_EN         1'b0
`define RST_IPMC_MAP            5'h00
`define RST_RL_PERIOD           2'h1
`define RST_EGR_QUEUE_MODE      1'b0
`define RST_DSCP_MAP            8'h00
`define RD_UNMAPPED             8'h00
`define RST_FRAME_PRIO          2'h0
`define RST_QUEUE_SEL           4'h1

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_KHZ                 10000
`define RL_PERIOD_SHORT_MS      16
`define RL_PERIOD_MID_MS        64
`define RL_PERIOD_LONG_MS       256

`endif

// >>> hdl/switch_ctrl_pkg.sv
/*
 * Types shared by the switch control bank and its DSCP lookup.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package switch_ctrl_pkg;

    typedef logic [1:0] prio_t;
    typedef logic [5:0] dscp_code_t;

    typedef enum logic [1:0] {
        PERIOD_SHORT,
        PERIOD_MID,
        PERIOD_LONG
    } rl_period_t;

endpackage

// >>> hdl/dscp_lookup_if.sv
/*
 * Carrier between the control bank and the DSCP priority lookup.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface dscp_lookup_if #(
    parameter int ENTRIES = 64
);
    logic [2*ENTRIES-1:0] map_bits;
    logic                 req_valid;
    logic [5:0]           req_code;
    logic                 res_valid;
    logic [1:0]           res_prio;
    logic [3:0]           res_queue;

    modport ctrl (output map_bits, req_valid, req_code,
                  input  res_valid, res_prio, res_queue);
    modport lkp  (input  map_bits, req_valid, req_code,
                  output res_valid, res_prio, res_queue);
endinterface

// >>> hdl/dscp_lookup.sv
/*
 * DSCP to priority lookup: picks one two-bit entry out of the flat map
 * and turns it into a one-hot egress queue select.
 * Assumes the map is held stable by the control bank.
 */
`timescale 1ns/1ps

`include "switch_ctrl_map.svh"

module dscp_lookup
    import switch_ctrl_pkg::*;
#(
    parameter int ENTRIES = 64
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // Lookup port
    dscp_lookup_if.lkp lk
);

    prio_t prio_d;
    logic  valid_q;
    prio_t prio_q;
    logic [3:0] queue_q;

    // Code n sits in bits 2n+1..2n of the map
    assign prio_d = lk.map_bits[{lk.req_code, 1'b0} +: 2];

    always_ff @(posedge mclk) begin
        if (rst) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= lk.req_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prio_q  <= `RST_FRAME_PRIO;
            queue_q <= `RST_QUEUE_SEL;
        end else if (lk.req_valid) begin
            prio_q  <= prio_d;
            queue_q <= 4'h1 << prio_d;
        end
    end

    assign lk.res_valid = valid_q;
    assign lk.res_prio  = prio_q;
    assign lk.res_queue = queue_q;

endmodule

// >>> hdl/switch_ctrl_bank.sv
/*
 * Global switch control bank: self-address filter, unknown IP multicast
 * forwarding, ingress rate-limit period timer, egress rate-limit mode and
 * the DSCP priority map with its lookup.
 * Assumes a simple strobe register port and frame-side requests from logic
 * on the same core clock, so no synchronisers are needed on them.
 * Assumes the self MAC address is held by a neighbouring bank and arrives
 * here as a steady word; the consumers of the settings sit outside.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ps

`include "switch_ctrl_map.svh"

module switch_ctrl_bank
    import switch_ctrl_pkg::*;
#(
    parameter int NUM_PORTS     = 5,
    parameter int MAP_REGS      = 16,
    parameter int PERIOD_SHORT  = `RL_PERIOD_SHORT_MS * `CLK_KHZ,
    parameter int PERIOD_MID    = `RL_PERIOD_MID_MS * `CLK_KHZ,
    parameter int PERIOD_LONG   = `RL_PERIOD_LONG_MS * `CLK_KHZ
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Self address, held outside this bank
    input  wire logic [47:0]          self_mac,
    // Egress filter request and verdict
    input  wire logic                 egr_valid,
    input  wire logic [47:0]          egr_dest_mac,
    output logic                      egr_verdict_valid,
    output logic                      egr_drop,
    // Unknown IP multicast request and forward set
    input  wire logic                 ipmc_valid,
    output logic                      ipmc_res_valid,
    output logic                      ipmc_use_map,
    output logic      [NUM_PORTS-1:0] ipmc_port_mask,
    // Rate limiting
    output logic                      ingress_period_tick,
    output logic                      egress_queue_mode,
    // DSCP lookup request and result
    input  wire logic                 tos_valid,
    input  wire logic [7:0]           tos_byte,
    output logic                      prio_valid,
    output logic      [1:0]           frame_prio,
    output logic      [3:0]           queue_sel
);

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    logic                 self_filter_en_q;
    logic                 ipmc_fwd_en_q;
    logic [NUM_PORTS-1:0] ipmc_map_q;
    logic [1:0]           rl_period_q;
    logic                 egr_queue_mode_q;
    logic [7:0]           dscp_map_q [MAP_REGS];
    logic [7:0]           rdata_q;

    logic                 wr_filter;
    logic                 wr_rate;
    logic                 wr_map;
    logic                 map_hit;
    logic [7:0]           map_index;
    logic [7:0]           rdata_d;

    assign wr_filter = reg_wr && (reg_addr == `OFS_FILTER_IPMC_CTRL);
    assign wr_rate   = reg_wr && (reg_addr == `OFS_RATE_LIMIT_CTRL);
    assign wr_map    = reg_wr && map_hit;
    assign map_index = reg_addr - `OFS_DSCP_MAP_BASE;
    assign map_hit   = (reg_addr >= `OFS_DSCP_MAP_BASE) &&
                       (map_index < 8'(MAP_REGS));

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Bit 7 is read-only; writes to it are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            self_filter_en_q <= `RST_SELF_FILTER_EN;
        end else if (wr_filter) begin
            self_filter_en_q <= reg_wdata[`BIT_SELF_FILTER_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ipmc_fwd_en_q <= `RST_IPMC_FWD_EN;
        end else if (wr_filter) begin
            ipmc_fwd_en_q <= reg_wdata[`BIT_IPMC_FWD_EN];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ipmc_map_q <= `RST_IPMC_MAP;
        end else if (wr_filter) begin
            ipmc_map_q <= reg_wdata[`FLD_IPMC_MAP_HI:`FLD_IPMC_MAP_LO];
        end
    end

    // Bits 7-6 reserved, bits 2-0 not implemented here
    always_ff @(posedge mclk) begin
        if (rst) begin
            rl_period_q <= `RST_RL_PERIOD;
        end else if (wr_rate) begin
            rl_period_q <= reg_wdata[`FLD_RL_PERIOD_HI:`FLD_RL_PERIOD_LO];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            egr_queue_mode_q <= `RST_EGR_QUEUE_MODE;
        end else if (wr_rate) begin
            egr_queue_mode_q <= reg_wdata[`BIT_EGR_QUEUE_MODE];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < MAP_REGS; i++) begin
                dscp_map_q[i] <= `RST_DSCP_MAP;
            end
        end else if (wr_map) begin
            dscp_map_q[map_index[3:0]] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Data stand only in the cycle after the strobe; zero otherwise
    always_comb begin
        rdata_d = `RD_UNMAPPED;
        if (reg_rd) begin
            if (reg_addr == `OFS_FILTER_IPMC_CTRL) begin
                rdata_d = {1'b0, self_filter_en_q, ipmc_fwd_en_q, ipmc_map_q};
            end else if (reg_addr == `OFS_RATE_LIMIT_CTRL) begin
                rdata_d = {2'b00, rl_period_q, egr_queue_mode_q, 3'b000};
            end else if (map_hit) begin
                rdata_d = dscp_map_q[map_index[3:0]];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= `RD_UNMAPPED;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Self-address filter
    // ------------------------------------------------------------------
    logic        egr_vld_q;
    logic        egr_drop_q;
    logic [47:0] group_mask;
    logic        self_hit;

    // Group bit ignored so the multicast form of the own address also hits
    assign group_mask = ~(48'h1 << `BIT_MAC_GROUP);
    assign self_hit   = (egr_dest_mac & group_mask) == (self_mac & group_mask);

    always_ff @(posedge mclk) begin
        if (rst) begin
            egr_vld_q <= 1'b0;
        end else begin
            egr_vld_q <= egr_valid;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            egr_drop_q <= 1'b0;
        end else if (egr_valid) begin
            egr_drop_q <= self_filter_en_q && self_hit;
        end
    end

    assign egr_verdict_valid = egr_vld_q;
    assign egr_drop          = egr_drop_q;

    // ------------------------------------------------------------------
    // Unknown IP multicast forwarding
    // ------------------------------------------------------------------
    logic                 ipmc_vld_q;
    logic                 ipmc_use_q;
    logic [NUM_PORTS-1:0] ipmc_mask_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ipmc_vld_q <= 1'b0;
        end else begin
            ipmc_vld_q <= ipmc_valid;
        end
    end

    // Disabled: mask held zero and the switch falls back to default flooding
    always_ff @(posedge mclk) begin
        if (rst) begin
            ipmc_use_q <= 1'b0;
        end else if (ipmc_valid) begin
            ipmc_use_q <= ipmc_fwd_en_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ipmc_mask_q <= '0;
        end else if (ipmc_valid) begin
            ipmc_mask_q <= ipmc_fwd_en_q ? ipmc_map_q : '0;
        end
    end

    assign ipmc_res_valid = ipmc_vld_q;
    assign ipmc_use_map   = ipmc_use_q;
    assign ipmc_port_mask = ipmc_mask_q;

    // ------------------------------------------------------------------
    // Ingress rate-limit period timer
    // ------------------------------------------------------------------
    rl_period_t  period_sel;
    logic [31:0] period_limit;
    logic [31:0] period_cnt_q;
    logic        period_end;
    logic        tick_q;

    // Enum names spelled out in full: the length parameters share them
    always_comb begin
        period_sel = rl_period_q[1] ? switch_ctrl_pkg::PERIOD_LONG :
                     (rl_period_q[0] ? switch_ctrl_pkg::PERIOD_MID :
                                       switch_ctrl_pkg::PERIOD_SHORT);
        case (period_sel)
            switch_ctrl_pkg::PERIOD_SHORT: period_limit = 32'(PERIOD_SHORT);
            switch_ctrl_pkg::PERIOD_MID:   period_limit = 32'(PERIOD_MID);
            switch_ctrl_pkg::PERIOD_LONG:  period_limit = 32'(PERIOD_LONG);
            default:                       period_limit = 32'(PERIOD_MID);
        endcase
    end

    assign period_end = (period_cnt_q >= period_limit - 32'h1);

    // Restart on a field write so a new period never runs on a stale count
    always_ff @(posedge mclk) begin
        if (rst || wr_rate || period_end) begin
            period_cnt_q <= 32'h0;
        end else begin
            period_cnt_q <= period_cnt_q + 32'h1;
        end
    end

    // No tick on a restart edge: the new period has only just begun
    always_ff @(posedge mclk) begin
        if (rst || wr_rate) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= period_end;
        end
    end

    assign ingress_period_tick = tick_q;
    assign egress_queue_mode   = egr_queue_mode_q;

    // ------------------------------------------------------------------
    // DSCP priority map and lookup
    // ------------------------------------------------------------------
    dscp_lookup_if #(.ENTRIES(4 * MAP_REGS)) lk_if ();

    for (genvar g = 0; g < MAP_REGS; g++) begin : g_map
        assign lk_if.map_bits[8*g +: 8] = dscp_map_q[g];
    end

    assign lk_if.req_valid = tos_valid;
    assign lk_if.req_code  = tos_byte[7:2];

    dscp_lookup #(
        .ENTRIES (4 * MAP_REGS)
    ) u_lookup (
        .mclk (mclk),
        .rst  (rst),
        .lk   (lk_if.lkp)
    );

    assign prio_valid = lk_if.res_valid;
    assign frame_prio = lk_if.res_prio;
    assign queue_sel  = lk_if.res_queue;

endmodule

// >>> verification/switch_ctrl_bank_props.sv
/*
 * Port checker for the switch control bank.
 * Assumes it is bound into switch_ctrl_bank; one clock, sync reset.
 */
`timescale 1ns/1ps

module switch_ctrl_bank_props #(
    parameter int NUM_PORTS = 5
) (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    // Frame side
    input wire logic [47:0]          self_mac,
    input wire logic                 egr_valid,
    input wire logic [47:0]          egr_dest_mac,
    input wire logic                 egr_verdict_valid,
    input wire logic                 egr_drop,
    input wire logic                 ipmc_valid,
    input wire logic                 ipmc_res_valid,
    input wire logic                 ipmc_use_map,
    input wire logic [NUM_PORTS-1:0] ipmc_port_mask,
    input wire logic                 ingress_period_tick,
    input wire logic                 egress_queue_mode,
    input wire logic                 tos_valid,
    input wire logic                 prio_valid,
    input wire logic [1:0]           frame_prio,
    input wire logic [3:0]           queue_sel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    sequence s_rd_ctrl;
        reg_rd && reg_addr == 8'h86;
    endsequence
    sequence s_rd_rate;
        reg_rd && reg_addr == 8'h87;
    endsequence
    sequence s_wr_rate;
        reg_wr && reg_addr == 8'h87;
    endsequence

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_ctrl_rsvd: assert property (s_rd_ctrl |=> !reg_rdata[7])
        else $error("reserved control bit reads one");
    a_rate_rsvd: assert property (s_rd_rate |=>
        reg_rdata[7:6] == 2'h0 && reg_rdata[2:0] == 3'h0)
        else $error("reserved rate bits read nonzero");
    a_mode_write: assert property (s_wr_rate |=> egress_queue_mode == $past(reg_wdata[3]))
        else $error("queue mode does not follow write");
    a_mode_hold: assert property (!(reg_wr && reg_addr == 8'h87) |=>
        $stable(egress_queue_mode))
        else $error("queue mode changed without write");
    a_tick_single: assert property (ingress_period_tick |=> !ingress_period_tick)
        else $error("period tick longer than one cycle");

    // ----------------------------------------
    // Frame-side answers
    // ----------------------------------------
    a_egr_answer: assert property (1'b1 |=> egr_verdict_valid == $past(egr_valid))
        else $error("filter verdict not one cycle after request");
    a_foreign_pass: assert property (egr_valid &&
        {egr_dest_mac[47:41], egr_dest_mac[39:0]} != {self_mac[47:41], self_mac[39:0]}
        |=> !egr_drop)
        else $error("foreign address dropped");
    a_ipmc_answer: assert property (ipmc_valid |=> ipmc_res_valid)
        else $error("multicast answer missing");
    a_ipmc_off: assert property (ipmc_res_valid && !ipmc_use_map |-> ipmc_port_mask == '0)
        else $error("port mask set while forwarding disabled");
    a_prio_answer: assert property (tos_valid |=> prio_valid)
        else $error("priority answer missing");
    a_queue_onehot: assert property (prio_valid |-> queue_sel == 4'h1 << frame_prio)
        else $error("queue select not one-hot of priority");
endmodule

bind switch_ctrl_bank switch_ctrl_bank_props #(.NUM_PORTS(NUM_PORTS)) chk_u (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .self_mac(self_mac),
    .egr_valid(egr_valid), .egr_dest_mac(egr_dest_mac),
    .egr_verdict_valid(egr_verdict_valid), .egr_drop(egr_drop),
    .ipmc_valid(ipmc_valid), .ipmc_res_valid(ipmc_res_valid),
    .ipmc_use_map(ipmc_use_map), .ipmc_port_mask(ipmc_port_mask),
    .ingress_period_tick(ingress_period_tick), .egress_queue_mode(egress_queue_mode),
    .tos_valid(tos_valid), .prio_valid(prio_valid), .frame_prio(frame_prio),
    .queue_sel(queue_sel));

// >>> verification/test_switch_ctrl_bank.sv
/*
 * Self-checking bench for the switch control bank.
 * Assumes rate periods shortened to 8/16/32 cycles by parameter.
 */
`timescale 1ns/1ps

module test_switch_ctrl_bank
    import switch_ctrl_pkg::*;
;
    logic        mclk, rst, reg_wr, reg_rd, egr_valid, ipmc_valid, tos_valid;
    logic        egr_verdict_valid, egr_drop, ipmc_res_valid, ipmc_use_map;
    logic        ingress_period_tick, egress_queue_mode, prio_valid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, tos_byte;
    logic [7:0]  mb [16];
    logic [47:0] self_mac, egr_dest_mac;
    logic [4:0]  ipmc_port_mask;
    logic [1:0]  frame_prio;
    logic [3:0]  queue_sel;
    int          n_mismatch, checked, cyc;

    switch_ctrl_bank #(.PERIOD_SHORT(8), .PERIOD_MID(16), .PERIOD_LONG(32)) dut_u (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .self_mac(self_mac),
        .egr_valid(egr_valid), .egr_dest_mac(egr_dest_mac),
        .egr_verdict_valid(egr_verdict_valid), .egr_drop(egr_drop),
        .ipmc_valid(ipmc_valid), .ipmc_res_valid(ipmc_res_valid),
        .ipmc_use_map(ipmc_use_map), .ipmc_port_mask(ipmc_port_mask),
        .ingress_period_tick(ingress_period_tick), .egress_queue_mode(egress_queue_mode),
        .tos_valid(tos_valid), .tos_byte(tos_byte), .prio_valid(prio_valid),
        .frame_prio(frame_prio), .queue_sel(queue_sel));

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task results;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Whole run needs well under 2000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end

    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata, exp);
    endtask

    task egr(input logic [47:0] m, input logic exp);
        @(posedge mclk);
        egr_valid <= 1'b1;
        egr_dest_mac <= m;
        @(posedge mclk);
        egr_valid <= 1'b0;
        #1;
        chk("egr_drop", {egr_verdict_valid, 6'h0, egr_drop}, {1'b1, 6'h0, exp});
    endtask

    task ipmc(input logic [7:0] exp);
        @(posedge mclk);
        ipmc_valid <= 1'b1;
        @(posedge mclk);
        ipmc_valid <= 1'b0;
        #1;
        chk("ipmc", {ipmc_res_valid, ipmc_use_map, 1'b0, ipmc_port_mask}, exp);
    endtask

    // Lowest TOS bit set so a lookup that uses the low bits shows up
    task lookup(input logic [5:0] c, input logic [1:0] p);
        @(posedge mclk);
        tos_valid <= 1'b1;
        tos_byte <= {c, 2'b01};
        @(posedge mclk);
        tos_valid <= 1'b0;
        #1;
        chk("prio", {prio_valid, 1'b0, frame_prio, queue_sel}, {1'b1, 1'b0, p, 4'h1 << p});
    endtask

    task period(input logic [1:0] p, input int exp);
        int n;
        wr(8'h87, {2'b00, p, 4'h0});
        n = 0;
        #1;
        while (ingress_period_tick !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (ingress_period_tick !== 1'b1 && n < 100);
        chk("period", 8'(n), 8'(exp));
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, reg_wr, reg_rd, egr_valid, ipmc_valid, tos_valid} = 6'h20;
        {reg_addr, reg_wdata, tos_byte} = '0;
        self_mac = 48'h0a1b2c3d4e5f;
        egr_dest_mac = '0;
        {n_mismatch, checked, cyc} = '0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h86, 8'h00);
        rd(8'h87, 8'h10);
        chk("qmode", {7'h0, egress_queue_mode}, 8'h00);
        rd(8'h90, 8'h00);
        lookup(6'h3f, 2'h0);
        wr(8'h86, 8'hff);
        rd(8'h86, 8'h7f);
        wr(8'h87, 8'hff);
        rd(8'h87, 8'h38);
        chk("qmode", {7'h0, egress_queue_mode}, 8'h01);
        egr(self_mac, 1'b1);
        egr(self_mac ^ 48'h010000000000, 1'b1);
        egr(self_mac ^ 48'h1, 1'b0);
        wr(8'h86, 8'h15);
        egr(self_mac, 1'b0);
        ipmc(8'h80);
        wr(8'h86, 8'h35);
        ipmc(8'hd5);
        wr(8'h86, 8'h3f);
        ipmc(8'hdf);
        wr(8'h86, 8'h20);
        ipmc(8'hc0);
        period(2'b00, 8);
        period(2'b01, 16);
        period(2'b10, 32);
        period(2'b11, 32);
        chk("qmode", {7'h0, egress_queue_mode}, 8'h00);
        for (int k = 0; k < 16; k++) begin
            mb[k] = 8'he4 ^ 8'(k * 27);
            wr(8'h90 + 8'(k), mb[k]);
        end
        rd(8'h91, mb[1]);
        for (int c = 0; c < 64; c++) begin
            lookup(6'(c), mb[c / 4][2 * (c % 4) +: 2]);
        end
        wr(8'ha0, 8'hff);
        rd(8'ha0, 8'h00);
        results();
    end
endmodule
